// ===== slsc_pkg.sv
package slsc_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_LINK_STATUS = 10'h208;
  localparam logic [9:0] IDX_CHAN_ENABLE = 10'h209;
  localparam logic [9:0] IDX_SYNC_HEADER = 10'h20F;
  localparam logic [9:0] IDX_SYNC_REQUEST_THRESHOLD = 10'h210;
  localparam logic [9:0] IDX_LINK_CTRL = 10'h2F0;
  localparam logic [9:0] IDX_LINK_FORMAT = 10'h2F1;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h2F2;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h2F3;

  // Link status field positions
  localparam int ST_LINK_UP = 6;
  localparam int ST_SYNC_LEVEL = 5;
  localparam int ST_REALIGNED = 4;
  localparam int ST_PHASE_SET = 3;
  localparam int ST_SER_LOCK = 2;
  localparam int ST_SAMP_LOCK = 0;

  // Channel enable field positions
  localparam int CH_ONE_CHANNEL = 2;
  localparam int CH_PAIR_TWO = 1;
  localparam int CH_PAIR_ONE = 0;

  // Link control field positions
  localparam int CTL_LINK_EN = 0;
  localparam int CTL_CAL_EN = 1;

  // Interrupt event positions
  localparam int IRQ_REALIGN = 0;
  localparam int IRQ_PHASE_SET = 1;
  localparam int IRQ_LINK_LOST = 2;
  localparam int IRQ_LOCK_LOST = 3;

  // Writable masks and reset values
  localparam logic [7:0] CHAN_WMASK = 8'h07;
  localparam logic [7:0] SHDR_WMASK = 8'h03;
  localparam logic [7:0] THR_WMASK = 8'h1F;
  localparam logic [7:0] CTRL_WMASK = 8'h03;
  localparam logic [7:0] IRQ_WMASK = 8'h0F;
  localparam logic [7:0] CHAN_RESET = 8'h03;
  localparam logic [7:0] SHDR_RESET = 8'h00;
  localparam logic [7:0] THR_RESET = 8'h03;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // Sync word content codes
  localparam logic [1:0] SH_CRC12 = 2'h0;
  localparam logic [1:0] SH_FEC = 2'h2;
endpackage

// ===== slsc_top.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Bit 6 mirrors live link-up state
// - Bit 5 returns live sync request level
// - Bit 4 sticky on SYSREF realign, W1C
// - Bit 3 set by first SYSREF after enable
// - Bit 2 mirrors serializer PLL lock
// - Bit 0 mirrors sampling PLL lock; 7,1 reserved
// - Bit 2 selects single channel, B-D off
// - Bit 1 enables pair C/D, resets one
// - Bit 0 enables pair A/B, resets one
// - One pair off halves lanes and converters
// - Odd lane count halved adds tail bits
// - Pair one off moves C/D to A/B slots
// - Select picks CRC-12 or FEC sync word
// - Command fields in sync word always zero
module slsc_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [11:0] wbAdrI,
  input wire logic [3:0] wbSelI,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  input wire logic linkUp,
  input wire logic syncReqN,
  input wire logic sysrefRealign,
  input wire logic sysrefEvent,
  input wire logic serializerPllLock,
  input wire logic samplingPllLock,
  output logic irq,
  output logic serialLinkEnable,
  output logic calEnable,
  output logic [3:0] channelEnable,
  output logic [3:0] activeLanes,
  output logic [3:0] activeConverters,
  output logic tailBitsEnable,
  output logic slotSwapCdToAb,
  output logic [4:0] syncThreshold,
  output logic syncWordCrc,
  output logic syncWordFec,
  output logic [1:0] syncWordCommand
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] chanEnable_reg;
  logic [7:0] syncHeader_reg;
  logic [7:0] syncThresh_reg;
  logic [7:0] linkCtrl_reg;
  logic [7:0] linkFormat_reg;
  logic [7:0] irqStatus_reg;
  logic [7:0] irqMask_reg;
  logic realigned_reg;
  logic phaseSet_reg;
  logic phaseArmed_reg;
  logic linkEnPrev_reg;
  logic linkUpPrev_reg;
  logic lockPrev_reg;
  logic [7:0] statusLive;
  logic [7:0] readByte;
  logic [9:0] regIndex;
  logic access;
  logic wrStrobe;
  logic [7:0] wrByte;
  logic phaseSetEvent;
  logic linkLost;
  logic lockLost;
  logic [7:0] irqEvents;
  logic pairOff;

  assign regIndex = wbAdrI[11:2];
  // Single-cycle wait state: request taken on the edge that raises ack
  assign access = wbCycI && wbStbI && !wbAckO;
  assign wrStrobe = access && wbWeI && wbSelI[0];
  assign wrByte = wbDatI[7:0];

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      wbAckO <= 1'b0;
    end else begin
      wbAckO <= access;
    end
  end

  always_comb begin
    statusLive = 8'h00;
    statusLive[slsc_pkg::ST_LINK_UP] = linkUp;
    statusLive[slsc_pkg::ST_SYNC_LEVEL] = syncReqN;
    statusLive[slsc_pkg::ST_REALIGNED] = realigned_reg;
    statusLive[slsc_pkg::ST_PHASE_SET] = phaseSet_reg;
    statusLive[slsc_pkg::ST_SER_LOCK] = serializerPllLock;
    statusLive[slsc_pkg::ST_SAMP_LOCK] = samplingPllLock;
  end

  always_comb begin
    case (regIndex)
      slsc_pkg::IDX_LINK_STATUS: readByte = statusLive;
      slsc_pkg::IDX_CHAN_ENABLE: readByte = chanEnable_reg;
      slsc_pkg::IDX_SYNC_HEADER: readByte = syncHeader_reg;
      slsc_pkg::IDX_SYNC_REQUEST_THRESHOLD: readByte = syncThresh_reg;
      slsc_pkg::IDX_LINK_CTRL: readByte = linkCtrl_reg;
      slsc_pkg::IDX_LINK_FORMAT: readByte = linkFormat_reg;
      slsc_pkg::IDX_IRQ_STATUS: readByte = irqStatus_reg;
      slsc_pkg::IDX_IRQ_MASK: readByte = irqMask_reg;
      default: readByte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wbDatO <= 32'h00000000;
    end else if (access && !wbWeI) begin
      wbDatO <= {24'h000000, readByte};
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Reserved bits masked off so they always read zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      chanEnable_reg <= slsc_pkg::CHAN_RESET;
    end else if (wrStrobe && regIndex == slsc_pkg::IDX_CHAN_ENABLE) begin
      chanEnable_reg <= wrByte & slsc_pkg::CHAN_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      syncHeader_reg <= slsc_pkg::SHDR_RESET;
    end else if (wrStrobe && regIndex == slsc_pkg::IDX_SYNC_HEADER) begin
      syncHeader_reg <= wrByte & slsc_pkg::SHDR_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      syncThresh_reg <= slsc_pkg::THR_RESET;
    end else if (wrStrobe && regIndex == slsc_pkg::IDX_SYNC_REQUEST_THRESHOLD) begin
      syncThresh_reg <= wrByte & slsc_pkg::THR_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      linkCtrl_reg <= slsc_pkg::CTRL_RESET;
    end else if (wrStrobe && regIndex == slsc_pkg::IDX_LINK_CTRL) begin
      linkCtrl_reg <= wrByte & slsc_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      linkFormat_reg <= slsc_pkg::FORMAT_RESET;
    end else if (wrStrobe && regIndex == slsc_pkg::IDX_LINK_FORMAT) begin
      linkFormat_reg <= wrByte;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqMask_reg <= slsc_pkg::IRQ_RESET;
    end else if (wrStrobe && regIndex == slsc_pkg::IDX_IRQ_MASK) begin
      irqMask_reg <= wrByte & slsc_pkg::IRQ_WMASK;
    end
  end

  // ----------------------------------------
  // Sticky alignment flags
  // ----------------------------------------
  // Arming on the enable edge so only the first SYSREF counts
  always_ff @(posedge mclk) begin
    if (rst) begin
      linkEnPrev_reg <= 1'b0;
      phaseArmed_reg <= 1'b0;
    end else begin
      linkEnPrev_reg <= linkCtrl_reg[slsc_pkg::CTL_LINK_EN];
      if (!linkCtrl_reg[slsc_pkg::CTL_LINK_EN]) begin
        phaseArmed_reg <= 1'b0;
      end else if (!linkEnPrev_reg) begin
        phaseArmed_reg <= 1'b1;
      end else if (sysrefEvent) begin
        phaseArmed_reg <= 1'b0;
      end
    end
  end

  assign phaseSetEvent = phaseArmed_reg && sysrefEvent;

  // Set beats a same-cycle write-one clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      realigned_reg <= 1'b0;
      phaseSet_reg <= 1'b0;
    end else begin
      if (sysrefRealign) begin
        realigned_reg <= 1'b1;
      end else if (wrStrobe && regIndex == slsc_pkg::IDX_LINK_STATUS
                   && wrByte[slsc_pkg::ST_REALIGNED]) begin
        realigned_reg <= 1'b0;
      end
      if (phaseSetEvent) begin
        phaseSet_reg <= 1'b1;
      end else if (wrStrobe && regIndex == slsc_pkg::IDX_LINK_STATUS
                   && wrByte[slsc_pkg::ST_PHASE_SET]) begin
        phaseSet_reg <= 1'b0;
      end
    end
  end
  // other status bits have no storage, writes ignored

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      linkUpPrev_reg <= 1'b0;
      lockPrev_reg <= 1'b0;
    end else begin
      linkUpPrev_reg <= linkUp;
      lockPrev_reg <= serializerPllLock && samplingPllLock;
    end
  end

  assign linkLost = linkUpPrev_reg && !linkUp;
  assign lockLost = lockPrev_reg && !(serializerPllLock && samplingPllLock);

  always_comb begin
    irqEvents = 8'h00;
    irqEvents[slsc_pkg::IRQ_REALIGN] = sysrefRealign;
    irqEvents[slsc_pkg::IRQ_PHASE_SET] = phaseSetEvent;
    irqEvents[slsc_pkg::IRQ_LINK_LOST] = linkLost;
    irqEvents[slsc_pkg::IRQ_LOCK_LOST] = lockLost;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqStatus_reg <= slsc_pkg::IRQ_RESET;
    end else if (wrStrobe && regIndex == slsc_pkg::IDX_IRQ_STATUS) begin
      irqStatus_reg <= (irqStatus_reg & ~wrByte) | irqEvents;
    end else begin
      irqStatus_reg <= irqStatus_reg | irqEvents;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  // ----------------------------------------
  // Channel and lane configuration outputs
  // ----------------------------------------
  // Both pairs off is undefined; treated here as pair-off halving
  assign pairOff = !chanEnable_reg[slsc_pkg::CH_PAIR_ONE]
                || !chanEnable_reg[slsc_pkg::CH_PAIR_TWO]
                || chanEnable_reg[slsc_pkg::CH_ONE_CHANNEL];

  always_ff @(posedge mclk) begin
    if (rst) begin
      serialLinkEnable <= 1'b0;
      calEnable <= 1'b0;
      channelEnable <= 4'h0;
      slotSwapCdToAb <= 1'b0;
    end else begin
      serialLinkEnable <= linkCtrl_reg[slsc_pkg::CTL_LINK_EN];
      calEnable <= linkCtrl_reg[slsc_pkg::CTL_CAL_EN];
      channelEnable[0] <= chanEnable_reg[slsc_pkg::CH_PAIR_ONE];
      channelEnable[1] <= chanEnable_reg[slsc_pkg::CH_PAIR_ONE]
                          && !chanEnable_reg[slsc_pkg::CH_ONE_CHANNEL];
      channelEnable[2] <= chanEnable_reg[slsc_pkg::CH_PAIR_TWO]
                          && !chanEnable_reg[slsc_pkg::CH_ONE_CHANNEL];
      channelEnable[3] <= chanEnable_reg[slsc_pkg::CH_PAIR_TWO]
                          && !chanEnable_reg[slsc_pkg::CH_ONE_CHANNEL];
      slotSwapCdToAb <= !chanEnable_reg[slsc_pkg::CH_PAIR_ONE];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      activeLanes <= 4'h0;
      activeConverters <= 4'h0;
      tailBitsEnable <= 1'b0;
    end else if (pairOff) begin
      activeLanes <= 4'((5'(linkFormat_reg[3:0]) + 5'h01) >> 1);
      activeConverters <= {1'b0, linkFormat_reg[7:5]};
      tailBitsEnable <= linkFormat_reg[0];
    end else begin
      activeLanes <= linkFormat_reg[3:0];
      activeConverters <= linkFormat_reg[7:4];
      tailBitsEnable <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sync word and SYNC threshold outputs
  // ----------------------------------------
  // Reserved select codes send neither CRC-12 nor FEC
  always_ff @(posedge mclk) begin
    if (rst) begin
      syncWordCrc <= 1'b0;
      syncWordFec <= 1'b0;
      syncWordCommand <= 2'h0;
      syncThreshold <= 5'h00;
    end else begin
      syncWordCrc <= syncHeader_reg[1:0] == slsc_pkg::SH_CRC12;
      syncWordFec <= syncHeader_reg[1:0] == slsc_pkg::SH_FEC;
      syncWordCommand <= 2'h0;
      syncThreshold <= syncThresh_reg[4:0];
    end
  end

endmodule // slsc_top

`default_nettype wire

// ===== slsc_props.sv
`timescale 1ns/1ps
`default_nettype none
module slsc_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [11:0] wbAdrI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAckO,
  input wire logic linkUp,
  input wire logic syncReqN,
  input wire logic serializerPllLock,
  input wire logic samplingPllLock,
  input wire logic [3:0] channelEnable,
  input wire logic tailBitsEnable,
  input wire logic slotSwapCdToAb,
  input wire logic syncWordCrc,
  input wire logic syncWordFec,
  input wire logic [1:0] syncWordCommand
);
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ack_after_req: assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO)
    else $error("ack missing");
  a_ack_one_cycle: assert property (wbAckO |=> !wbAckO)
    else $error("ack too long");
  a_status_live_bits: assert property (
    wbAckO && $past(wbCycI && wbStbI && !wbWeI && wbAdrI == 12'h820) |->
    wbDatO[7:0] == {1'b0, $past(linkUp), $past(syncReqN), wbDatO[4:3],
    $past(serializerPllLock), 1'b0, $past(samplingPllLock)})
    else $error("status bits wrong");
  a_command_idle: assert property (syncWordCommand == 2'h0)
    else $error("command not idle");
  a_word_exclusive: assert property (!(syncWordCrc && syncWordFec))
    else $error("crc and fec both");
  a_pair_two: assert property (channelEnable[3] == channelEnable[2])
    else $error("pair two split");
  a_b_needs_a: assert property (channelEnable[1] |-> channelEnable[0])
    else $error("B without A");
  // Outputs still hold their reset zeros on the first edge after release
  a_swap_slots: assert property (!$past(rst) |-> slotSwapCdToAb != channelEnable[0])
    else $error("slot swap wrong");
  a_tail_halved: assert property (tailBitsEnable |-> channelEnable != 4'hF)
    else $error("tail while full");
endmodule // slsc_props
bind slsc_top slsc_props u_props (.*);
`default_nettype wire

// ===== slsc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module slsc_far_end (
  input wire logic mclk,
  input wire logic rst,
  input wire logic serialLinkEnable,
  output logic syncReqN,
  output logic linkUp
);
  // ----------
  // Receiver
  // ----------
  logic [3:0] waitReg;
  // Sync request held low until lanes settle
  always_ff @(posedge mclk) begin
    if (rst || !serialLinkEnable) begin
      waitReg <= 4'h0;
    end else if (waitReg != 4'hF) begin
      waitReg <= waitReg + 4'h1;
    end
  end
  assign syncReqN = (waitReg == 4'hF);
  assign linkUp = (waitReg == 4'hF);
endmodule // slsc_far_end
`default_nettype wire

// ===== tb_serial_link_status_channel_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_link_status_channel_cfg;
  logic mclk, rst, wbCycI, wbStbI, wbWeI, wbAckO, linkUp, syncReqN, irq;
  logic sysrefRealign, sysrefEvent, serializerPllLock, samplingPllLock;
  logic serialLinkEnable, calEnable, tailBitsEnable, slotSwapCdToAb;
  logic syncWordCrc, syncWordFec;
  logic [11:0] wbAdrI;
  logic [3:0] wbSelI, channelEnable, activeLanes, activeConverters, lx;
  logic [31:0] wbDatI, wbDatO;
  logic [4:0] syncThreshold;
  logic [1:0] syncWordCommand;
  logic [7:0] q, thr;
  logic [2:0] chv [4];
  int errors, compares, tickCount;
  slsc_top DUT (.*);
  slsc_far_end u_far (.*);
  // ----------
  // Helpers
  // ----------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    tickCount++;
    if (tickCount == 3000) begin
      errors++;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= w;
    wbAdrI <= a;
    wbDatI <= {24'h0, d};
    // No limit here: only the bench timeout ends a hung access
    do begin
      @(posedge mclk);
    end while (wbAckO !== 1'b1);
    q = wbDatO[7:0];
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic pulse(input logic realign);
    sysrefRealign <= realign;
    sysrefEvent <= !realign;
    @(posedge mclk);
    sysrefRealign <= 1'b0;
    sysrefEvent <= 1'b0;
  endtask
  function automatic logic [7:0] stExp(input logic r, input logic p);
    return {1'b0, linkUp, syncReqN, r, p, serializerPllLock, 1'b0, samplingPllLock};
  endfunction
  function automatic logic [3:0] chExp(input logic [2:0] c);
    return c[2] ? {3'h0, c[0]} : {c[1], c[1], c[0], c[0]};
  endfunction
  function automatic logic [3:0] laneExp(input logic [2:0] c);
    return (c == 3'h3) ? lx : 4'((5'(lx) + 5'h1) >> 1);
  endfunction
  // ----------
  // Sequence
  // ----------
  initial begin
    {wbCycI, wbStbI, wbWeI, sysrefRealign, sysrefEvent} = '0;
    {serializerPllLock, samplingPllLock, wbAdrI, wbDatI} = '0;
    wbSelI = 4'hF;
    rst = 1'b1;
    chv = '{3'h3, 3'h2, 3'h1, 3'h5};
    void'($urandom(32'hea87));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(12'h824, 8'h03, "chanEnable");
    rd(12'h83C, 8'h00, "syncHeader");
    rd(12'h840, 8'h03, "syncThresh");
    repeat (6) begin
      serializerPllLock <= 1'($urandom);
      samplingPllLock <= 1'($urandom);
      bus(1'b1, 12'h820, 8'hFF);
      rd(12'h820, stExp(1'b0, 1'b0), "status");
    end
    bus(1'b1, 12'hBCC, 8'h00);
    pulse(1'b1);
    repeat (2) @(posedge mclk);
    chk("irqMasked", 8'h00, {7'h0, irq});
    bus(1'b1, 12'hBCC, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    rd(12'h820, stExp(1'b1, 1'b0), "realigned");
    bus(1'b1, 12'h820, 8'h10);
    bus(1'b1, 12'hBC8, 8'h01);
    chk("irqClear", 8'h00, {7'h0, irq});
    rd(12'h820, stExp(1'b0, 1'b0), "realignClear");
    // Even and odd full lane counts, so tail padding is seen both ways
    for (int f = 0; f < 2; f++) begin
      lx = {3'($urandom_range(7, 1)), f[0]};
      bus(1'b1, 12'hBC4, {4'h8, lx});
      foreach (chv[i]) begin
        bus(1'b1, 12'h824, {5'h00, chv[i]});
        rd(12'h824, {5'h00, chv[i]}, "chanEnable");
        chk("channels", {4'h0, chExp(chv[i])}, {4'h0, channelEnable});
        chk("lanes", {4'h0, laneExp(chv[i])}, {4'h0, activeLanes});
        chk("conv", (chv[i] == 3'h3) ? 8'h08 : 8'h04, {4'h0, activeConverters});
        chk("tail", {7'h0, chv[i] != 3'h3 && lx[0]}, {7'h0, tailBitsEnable});
        chk("swap", {7'h0, !chv[i][0]}, {7'h0, slotSwapCdToAb});
      end
    end
    for (int v = 0; v < 4; v++) begin
      bus(1'b1, 12'h83C, 8'(v));
      rd(12'h83C, 8'(v), "syncHeader");
      chk("crc", {7'h0, v == 0}, {7'h0, syncWordCrc});
      chk("fec", {7'h0, v == 2}, {7'h0, syncWordFec});
      chk("command", 8'h00, {6'h0, syncWordCommand});
    end
    // Byte lane zero off: the write must be ignored
    thr = 8'($urandom);
    wbSelI <= 4'hE;
    bus(1'b1, 12'h840, thr);
    wbSelI <= 4'hF;
    rd(12'h840, 8'h03, "selIgnored");
    bus(1'b1, 12'h840, thr);
    rd(12'h840, thr & 8'h1F, "syncThresh");
    chk("threshOut", thr & 8'h1F, {3'h0, syncThreshold});
    bus(1'b1, 12'hBC0, 8'h01);
    chk("linkEnable", 8'h01, {7'h0, serialLinkEnable});
    chk("calEnable", 8'h00, {7'h0, calEnable});
    repeat (20) @(posedge mclk);
    pulse(1'b0);
    rd(12'h820, stExp(1'b0, 1'b1), "phaseSet");
    bus(1'b1, 12'h820, 8'h08);
    pulse(1'b0);
    rd(12'h820, stExp(1'b0, 1'b0), "phaseOnce");
    bus(1'b1, 12'hBC8, 8'h0F);
    rd(12'hBC8, 8'h00, "irqCleared");
    serializerPllLock <= 1'b1;
    samplingPllLock <= 1'b1;
    repeat (2) @(posedge mclk);
    serializerPllLock <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(12'hBC8, 8'h08, "lockLost");
    // Link off drops the far end, which takes two more edges to show
    bus(1'b1, 12'hBC0, 8'h02);
    repeat (2) @(posedge mclk);
    rd(12'hBC8, 8'h0C, "linkLost");
    chk("linkOff", 8'h00, {7'h0, serialLinkEnable});
    chk("calOn", 8'h01, {7'h0, calEnable});
    bus(1'b1, 12'h7FC, 8'hAA);
    rd(12'h7FC, 8'h00, "unmapped");
    tally_and_finish;
  end
endmodule // tb_serial_link_status_channel_cfg
`default_nettype wire
